// [inc/safifo_params.svh]
`ifndef SAFIFO_PARAMS_SVH
`define SAFIFO_PARAMS_SVH
// storage depth in words
`define SAFIFO_DEPTH 64
// pointer width, one extra bit for wrap
`define SAFIFO_PTR_W 7
// almost-boundary limits: below low or above high
`define SAFIFO_ALMOST_LO 9
`define SAFIFO_ALMOST_HI 55
// half-level threshold: more than this many words
`define SAFIFO_HALF_TH 31
// default data width
`define SAFIFO_DATA_W 9
`endif

// [inc/safifo_pkg.sv]
package safifo_pkg;
  // status flags travelling together
  typedef struct packed {
    logic empty_n;
    logic full_n;
    logic almost_boundary;
    logic half_level;
  } safifo_flags_t;
endpackage

// [src/safifo_top.sv]
`timescale 1ns/1ps
`include "safifo_params.svh"
// Behaviour
// - load strobe rising edge stores word
// - unload strobe rising edge advances output word
// - output enable high drives outputs
// - reset clears pointers, forces empty
// - empty released by load, set by unload/reset
// - unload ignored while empty
// - full set by load, released by unload/reset
// - load ignored while full
// - almost flag below nine or above 55
// - half flag above 31 words
// - data width 8 or 9 bits
// - storage holds 64 words
// - first word appears without unload
// - strobes independent, possibly asynchronous
module safifo_top
  import safifo_pkg::*;
#(
  parameter int DATA_W = `SAFIFO_DATA_W
)
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // strobes and output enable, asynchronous pins
  input wire logic I_LOAD_STROBE,
  input wire logic I_UNLOAD_STROBE,
  input wire logic I_OUT_DRIVE_EN,
  // write data
  input wire logic [DATA_W-1:0] I_WRITE_DATA_IN,
  // read data, two signals of a tri-state pin
  output logic [DATA_W-1:0] O_READ_DATA_OUT,
  output logic O_READ_DATA_OE_N,
  // status flags
  output logic O_EMPTY_N,
  output logic O_FULL_N,
  output logic O_ALMOST_BOUNDARY_FLAG,
  output logic O_HALF_LEVEL_FLAG
);

  localparam int DEPTH = `SAFIFO_DEPTH;
  localparam int PW = `SAFIFO_PTR_W;
  localparam logic [PW-1:0] DEPTH_C = PW'(`SAFIFO_DEPTH);
  localparam logic [PW-1:0] ALO_C = PW'(`SAFIFO_ALMOST_LO);
  localparam logic [PW-1:0] AHI_C = PW'(`SAFIFO_ALMOST_HI);
  localparam logic [PW-1:0] HALF_C = PW'(`SAFIFO_HALF_TH);

  // strobe and enable synchroniser chains
  logic [2:0] ld_sync_r;
  logic [2:0] un_sync_r;
  logic [1:0] oe_sync_r;
  // write data pipeline and storage
  logic [DATA_W-1:0] wd_s1_r;
  logic [DATA_W-1:0] wd_s2_r;
  logic [DATA_W-1:0] mem_r [0:DEPTH-1];
  // pointers carry one wrap bit above the address
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] count;
  // strobe edges and accepted strobe events, one clock wide
  logic ld_edge;
  logic un_edge;
  logic do_wr;
  logic do_rd;
  logic [PW-1:0] cnt_nxt;
  // address of the word behind the head, wraps over the depth
  logic [PW-2:0] rd_next_idx;
  // next flag values, one set for all four outputs
  safifo_flags_t flags_nxt;

  // load strobe chain, cleared to the idle low level
  // so that no false edge follows reset
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      ld_sync_r <= 3'h0;
    else
      ld_sync_r <= {ld_sync_r[1:0], I_LOAD_STROBE};
  end

  // unload strobe chain, independent of the load chain
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      un_sync_r <= 3'h0;
    else
      un_sync_r <= {un_sync_r[1:0], I_UNLOAD_STROBE};
  end

  // output enable chain, two clocks of latency
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      oe_sync_r <= 2'h0;
    else
      oe_sync_r <= {oe_sync_r[0], I_OUT_DRIVE_EN};
  end

  // data pins synchronised alongside the strobe, same depth
  always_ff @(posedge I_CLK)
  begin
    wd_s1_r <= I_WRITE_DATA_IN;
    wd_s2_r <= wd_s1_r;
  end

  // rising edges seen after the second stage
  assign ld_edge = ld_sync_r[1] & ~ld_sync_r[2];
  assign un_edge = un_sync_r[1] & ~un_sync_r[2];
  assign count = wr_ptr_r - rd_ptr_r;
  assign do_wr = ld_edge && (count != DEPTH_C);
  assign do_rd = un_edge && (count != '0);

  // refused strobes are dropped, never held for later
  // next head address, slice keeps the index inside the depth
  assign rd_next_idx = rd_ptr_r[PW-2:0] + (PW-1)'(1);

  // memory write on accepted load
  always_ff @(posedge I_CLK)
  begin
    if (do_wr)
      mem_r[wr_ptr_r[PW-2:0]] <= wd_s2_r;
  end

  // write pointer, wraps through the extra bit
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      wr_ptr_r <= '0;
    else if (do_wr)
      wr_ptr_r <= wr_ptr_r + PW'(1);
  end

  // read pointer, moves only on accepted unloads
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      rd_ptr_r <= '0;
    else if (do_rd)
      rd_ptr_r <= rd_ptr_r + PW'(1);
  end

  // next count and flags from accepted strobes
  // both accepted strobes in one clock leave the count unchanged
  // count is taken from pointers of one clock, so no
  // word crosses between strobe domains here
  always_comb
  begin
    cnt_nxt = count;
    if (do_wr && !do_rd)
      cnt_nxt = count + PW'(1);
    else if (do_rd && !do_wr)
      cnt_nxt = count - PW'(1);
    flags_nxt.empty_n = (cnt_nxt != '0);
    flags_nxt.full_n = (cnt_nxt != DEPTH_C);
    flags_nxt.almost_boundary = (cnt_nxt < ALO_C) || (cnt_nxt > AHI_C);
    flags_nxt.half_level = (cnt_nxt > HALF_C);
  end

  // empty flag, low after reset or the last unload
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      O_EMPTY_N <= 1'b0;
    else
      O_EMPTY_N <= flags_nxt.empty_n;
  end

  // full flag, low only after the 64th load
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      O_FULL_N <= 1'b1;
    else
      O_FULL_N <= flags_nxt.full_n;
  end

  // almost-boundary flag, high in the empty state
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      O_ALMOST_BOUNDARY_FLAG <= 1'b1;
    else
      O_ALMOST_BOUNDARY_FLAG <= flags_nxt.almost_boundary;
  end

  // half-level flag, low in the empty state
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      O_HALF_LEVEL_FLAG <= 1'b0;
    else
      O_HALF_LEVEL_FLAG <= flags_nxt.half_level;
  end

  // head word shown directly, first load falls through
  // empty after this clock: last word is simply kept
  // one word left with load and unload together: new word is head
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      O_READ_DATA_OUT <= '0;
    else if (cnt_nxt == '0)
      O_READ_DATA_OUT <= O_READ_DATA_OUT;
    else if (count == '0 || (do_rd && cnt_nxt == PW'(1) && do_wr))
      O_READ_DATA_OUT <= wd_s2_r;
    else if (do_rd)
      O_READ_DATA_OUT <= mem_r[rd_next_idx];
  end

  // output drive, enable low while driving
  // released during reset so the pins float until enabled
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
      O_READ_DATA_OE_N <= 1'b1;
    else
      O_READ_DATA_OE_N <= ~oe_sync_r[1];
  end

endmodule // safifo_top

// [tb/safifo_monitor.sv]
`timescale 1ns/1ps
module safifo_monitor (
  // watched ports
  input wire logic I_CLK, I_RSTN, I_LOAD_STROBE, I_UNLOAD_STROBE,
  input wire logic I_OUT_DRIVE_EN, O_READ_DATA_OE_N, O_EMPTY_N,
  input wire logic O_FULL_N, O_ALMOST_BOUNDARY_FLAG, O_HALF_LEVEL_FLAG
);
  // flags tied to reset, to the strobe that moved them and to each other; output drive tied to enable
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  chk_rst_empty: assert property ($rose(I_RSTN) |-> !O_EMPTY_N && O_FULL_N)
    else $error("not empty after reset");
  chk_empty_rel: assert property ($rose(O_EMPTY_N) |-> $past(I_LOAD_STROBE, 3))
    else $error("empty left without load");
  chk_empty_set: assert property ($fell(O_EMPTY_N) |-> $past(I_UNLOAD_STROBE, 3))
    else $error("empty set without unload");
  chk_full_set: assert property ($fell(O_FULL_N) |-> $past(I_LOAD_STROBE, 3))
    else $error("full set without load");
  chk_full_rel: assert property ($rose(O_FULL_N) |-> $past(I_UNLOAD_STROBE, 3))
    else $error("full left without unload");
  chk_full_flags: assert property (!O_FULL_N |-> O_HALF_LEVEL_FLAG && O_ALMOST_BOUNDARY_FLAG)
    else $error("flags wrong when full");
  chk_empty_flags: assert property (!O_EMPTY_N |-> O_ALMOST_BOUNDARY_FLAG && !O_HALF_LEVEL_FLAG)
    else $error("flags wrong when empty");
  chk_oe_drive: assert property (I_OUT_DRIVE_EN [*4] |-> !O_READ_DATA_OE_N)
    else $error("outputs not driven");
  chk_oe_float: assert property (!I_OUT_DRIVE_EN [*4] |-> O_READ_DATA_OE_N)
    else $error("outputs not released");
endmodule // safifo_monitor

// [tb/safifo_reader.sv]
`timescale 1ns/1ps
// reading side: resolves the three-state bus
module safifo_reader (input wire logic oe_n, input wire logic [8:0] d,
  output logic [8:0] bus);
  logic [8:0] last = 9'h0;
  // released bus shows inverse of last value
  always @* if (!oe_n) last = d;
  assign bus = oe_n ? ~last : d;
endmodule // safifo_reader

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import safifo_pkg::*;
  logic I_CLK = 0, I_RSTN = 0, ld = 0, ul = 0, en = 1, oe_n;
  logic [8:0] wd = 9'h0, rd, bus, mq[$];
  logic [9:0] dq[$], nd;
  safifo_flags_t fl, fq[$];
  int n = 0, err_total = 0, checks = 0;
  event ev;
  initial forever #2 I_CLK = ~I_CLK;
  safifo_top u_dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_LOAD_STROBE(ld),
    .I_UNLOAD_STROBE(ul), .I_OUT_DRIVE_EN(en), .I_WRITE_DATA_IN(wd),
    .O_READ_DATA_OUT(rd), .O_READ_DATA_OE_N(oe_n), .O_EMPTY_N(fl.empty_n),
    .O_FULL_N(fl.full_n), .O_ALMOST_BOUNDARY_FLAG(fl.almost_boundary),
    .O_HALF_LEVEL_FLAG(fl.half_level));
  safifo_reader u_rd (.oe_n(oe_n), .d(rd), .bus(bus));
  task complete_run;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task fail(input string m);
    err_total++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task cmp_f(input safifo_flags_t e);
    checks++;
    if (fl !== e) fail("flags");
  endtask
  task cmp_d(input logic [8:0] e);
    checks++;
    if (bus !== e) fail("data");
  endtask
  // expected flags and head word from the model count
  task note;
    fq.push_back('{n != 0, n != 64, n < 9 || n > 55, n > 31});
    dq.push_back({n > 0, n > 0 ? mq[0] : 9'h0});
    -> ev;
  endtask
  // one strobe pulse, four cycles high and four low
  task op(input bit w);
    if (w) ld = 1;
    else ul = 1;
    repeat (4) @(negedge I_CLK);
    ld = 0;
    ul = 0;
    if (w && n < 64) mq.push_back(wd);
    if (!w && n > 0) void'(mq.pop_front());
    n = mq.size();
    wd = 9'($urandom);
    repeat (4) @(negedge I_CLK);
    note();
  endtask
  // compares each note against settled outputs
  always @(ev)
  begin
    cmp_f(fq.pop_front());
    nd = dq.pop_front();
    if (nd[9]) cmp_d(nd[8:0]);
  end
  initial
  begin
    void'($urandom(32'h63DA2B26));
    repeat (3) @(negedge I_CLK);
    I_RSTN = 1;
    note();
    repeat (66) op(1);
    en = 0;
    repeat (6) @(negedge I_CLK);
    en = 1;
    repeat (66) op(0);
    repeat (40) op(1'($urandom));
    I_RSTN = 0;
    mq.delete();
    n = 0;
    repeat (3) @(negedge I_CLK);
    I_RSTN = 1;
    note();
    complete_run();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge I_CLK);
    fail("timeout");
    complete_run();
  end
endmodule // tb
bind safifo_top safifo_monitor u_mon (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
  .I_LOAD_STROBE(I_LOAD_STROBE), .I_UNLOAD_STROBE(I_UNLOAD_STROBE),
  .I_OUT_DRIVE_EN(I_OUT_DRIVE_EN), .O_READ_DATA_OE_N(O_READ_DATA_OE_N),
  .O_EMPTY_N(O_EMPTY_N), .O_FULL_N(O_FULL_N),
  .O_ALMOST_BOUNDARY_FLAG(O_ALMOST_BOUNDARY_FLAG),
  .O_HALF_LEVEL_FLAG(O_HALF_LEVEL_FLAG));
